/* File: pkg/sas_consts.vh */
// constants for the sar adc sequencer: register map, fields, reset values, timing
`ifndef SAS_CONSTS_VH
`define SAS_CONSTS_VH
// register byte offsets
`define SAS_OFS_CTRL 8'h00
`define SAS_OFS_CFG 8'h04
`define SAS_OFS_TIMING 8'h08
`define SAS_OFS_RESULT 8'h0C
`define SAS_OFS_STATUS 8'h10
// control register bits
`define SAS_CTRL_EN 0
`define SAS_CTRL_START 1
`define SAS_CTRL_CONT 2
`define SAS_CTRL_SE 3
`define SAS_CTRL_CHOP 4
`define SAS_CTRL_DONE 5
`define SAS_CTRL_IRQEN 6
`define SAS_CTRL_DMAEN 7
// configuration register fields
`define SAS_CFG_ATTN_LSB 0
`define SAS_CFG_AVG_LSB 2
`define SAS_CFG_SDEL_LSB 8
`define SAS_CFG_CHAN_LSB 16
// timing register fields
`define SAS_TIM_PUD_LSB 0
`define SAS_TIM_IVL_LSB 8
// reset values
`define SAS_PUD_RESET 8'h40
`define SAS_CFG_RESET 32'h0000_0000
// timing
`define SAS_PUD_UNIT 4
`define SAS_CLK_KHZ 40000
`define SAS_TICK_NS 1024000
`define SAS_TICK_CYCLES ((`SAS_TICK_NS / 1000) * (`SAS_CLK_KHZ / 1000))
`endif

/* File: rtl/sas_tick_gen.v */
// slow delay clock: one-cycle enable pulse every interval step
`timescale 1ns/1ps
`default_nettype none
module sas_tick_gen #(
  parameter integer TICK_CYCLES = 40960
) (
  input wire sys_clk,
  input wire srst,
  output reg tick
);
  reg [19:0] cnt_q;

  always @(posedge sys_clk) begin
    if (srst) begin
      cnt_q <= 20'h00000;
      tick <= 1'b0;
    end else if (cnt_q == TICK_CYCLES[19:0] - 20'h00001) begin
      cnt_q <= 20'h00000;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 20'h00001;
      tick <= 1'b0;
    end
  end
endmodule // sas_tick_gen
`default_nettype wire

/* File: rtl/sas_ahb_slave.v */
// ahb-lite slave front end: captures the address phase, issues write strobes
`timescale 1ns/1ps
`default_nettype none
module sas_ahb_slave (
  input wire sys_clk,
  input wire srst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  output wire rdTake,
  output wire [7:0] rdAddr,
  output reg wrStb,
  output reg [7:0] wrAddr,
  output reg hreadyout,
  output reg hresp
);
  wire take;

  // a transfer is taken on a nonseq or seq address phase while the bus is ready
  assign take = hsel & htrans[1] & hready;
  assign rdTake = take & ~hwrite;
  assign rdAddr = haddr[7:0];

  always @(posedge sys_clk) begin
    if (srst) begin
      wrStb <= 1'b0;
      wrAddr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wrStb <= take & hwrite;
      if (take) begin
        wrAddr <= haddr[7:0];
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule // sas_ahb_slave
`default_nettype wire

/* File: rtl/sas_sequencer.v */
// sar adc sequencer: registers, power-up, conversion control, averaging, result
`timescale 1ns/1ps
`default_nettype none
`include "sas_consts.vh"
// What this block does
// (RULE1) enable bit powers regulator first, converter after power-up delay, then conversions
// (RULE2) power-up delay counts in units of four clock cycles, reset 0x40
// (RULE3) all control logic runs on the single system clock
// (RULE4) writing one to start begins a conversion; start reads one while busy
// (RULE5) on completion start clears, done flag sets, result holds valid value
// (RULE6) start writes during an active conversion are ignored
// (RULE7) software checks start reads zero before requesting a new conversion
// (RULE8) continuous mode restarts automatically; one start write launches the first
// (RULE9) continuous mode overwrites the result after every conversion
// (RULE10) software clears continuous bit then waits for start to clear
// (RULE11) software leaves continuous mode before changing configuration
// (RULE12) continuous gap set in 1.024 ms steps; zero restarts immediately
// (RULE13) non-zero interval first synchronises to the slow delay tick
// (RULE14) channel code 0..13 routed to the converter input selector
// (RULE15) single-ended or differential mode bit drives the converter
// (RULE16) two-bit attenuation field drives input scaling 1x to 4x
// (RULE17) averaging of up to 128 samples into one stored result
// (RULE18) software clears enable when converter is unused
// (RULE19) store delay zero waits for handshake, else stores after delay plus one
// (RULE20) chopper runs sample pairs with inverted offset sign, summed
// (RULE21) interrupt output high while done flag set and unmasked
// (RULE22) one dma request pulse per stored result
module sas_sequencer #(
  parameter integer TICK_CYCLES = `SAS_TICK_CYCLES
) (
  input wire sys_clk,
  input wire srst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  output reg ldoEnable,
  output reg adcEnable,
  output reg convStart,
  output reg [3:0] channelSel,
  output reg singleEnded,
  output reg [1:0] attenuation,
  output reg offsetSign,
  input wire convDone,
  input wire [9:0] convData,
  output reg irq,
  output reg dmaReq
);
  // ------------------------------------------------------------------
  // states
  // ------------------------------------------------------------------
  localparam [2:0] S_OFF = 3'h0;
  localparam [2:0] S_PWRUP = 3'h1;
  localparam [2:0] S_IDLE = 3'h2;
  localparam [2:0] S_CONV = 3'h3;
  localparam [2:0] S_STORE = 3'h4;
  localparam [2:0] S_GAP = 3'h5;

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  wire rdTake;
  wire [7:0] rdAddr;
  wire wrStb;
  wire [7:0] wrAddr;
  wire tick;
  wire wrCtrl, wrCfg, wrTim;
  reg enable_q, start_q, cont_q, se_q, chop_q, done_q, irqEn_q, dmaEn_q;
  reg [1:0] attn_q;
  reg [2:0] avg_q;
  reg [7:0] storeDel_q, pud_q, ivl_q, smpCnt_q, gapCnt_q;
  reg [3:0] chan_q;
  reg [15:0] result_q;
  reg [2:0] state_q;
  reg [9:0] pwrCnt_q;
  reg [8:0] dlyCnt_q;
  reg [16:0] acc_q;
  reg storeNow, hwClrStart, hwSetDone;
  reg [7:0] smpTotal;
  reg [2:0] avgShift;
  reg [23:0] scaled;
  reg [31:0] rdMux;
  // ------------------------------------------------------------------
  // bus front end and slow tick
  // ------------------------------------------------------------------
  sas_ahb_slave u_bus (
    .sys_clk(sys_clk),
    .srst(srst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .rdTake(rdTake),
    .rdAddr(rdAddr),
    .wrStb(wrStb),
    .wrAddr(wrAddr),
    .hreadyout(hreadyout),
    .hresp(hresp)
  );

  sas_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .sys_clk(sys_clk),
    .srst(srst),
    .tick(tick)
  );

  assign wrCtrl = wrStb & (wrAddr == `SAS_OFS_CTRL);
  assign wrCfg = wrStb & (wrAddr == `SAS_OFS_CFG);
  assign wrTim = wrStb & (wrAddr == `SAS_OFS_TIMING);

  // ------------------------------------------------------------------
  // derived sample count and result scaling
  // ------------------------------------------------------------------
  always @* begin
    smpTotal = 8'h01 << avg_q; // (RULE17)
    avgShift = avg_q;
    if (chop_q && avg_q == 3'h0) begin
      smpTotal = 8'h02; // (RULE20)
      avgShift = 3'h1;
    end
    // 10-bit samples stored left aligned in 16 bits after dividing by count
    scaled = ({7'h00, acc_q} << 6) >> avgShift;
  end
  // store moment: handshake or fixed delay
  always @* begin
    if (storeDel_q == 8'h00) begin
      storeNow = convDone; // (RULE19)
    end else begin
      storeNow = (dlyCnt_q == 9'h000); // (RULE19)
    end
  end

  // ------------------------------------------------------------------
  // register read mux, answered in the data phase
  // ------------------------------------------------------------------
  always @* begin
    case (rdAddr)
      `SAS_OFS_CTRL: begin
        rdMux = {24'h000000, dmaEn_q, irqEn_q, done_q, chop_q, se_q, cont_q,
                 start_q, enable_q}; // (RULE4)
      end
      `SAS_OFS_CFG: begin
        rdMux = {12'h000, chan_q, storeDel_q, 3'h0, avg_q, attn_q};
      end
      `SAS_OFS_TIMING: begin
        rdMux = {16'h0000, ivl_q, pud_q};
      end
      `SAS_OFS_RESULT: begin
        rdMux = {16'h0000, result_q};
      end
      `SAS_OFS_STATUS: begin
        rdMux = {27'h0000000, state_q, adcEnable, ldoEnable};
      end
      default: begin
        rdMux = 32'h00000000;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      hrdata <= 32'h00000000;
    end else if (rdTake) begin
      hrdata <= rdMux;
    end
  end

  // ------------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (srst) begin
      enable_q <= 1'b0;
      cont_q <= 1'b0;
      se_q <= 1'b0;
      chop_q <= 1'b0;
      irqEn_q <= 1'b0;
      dmaEn_q <= 1'b0;
      attn_q <= 2'h0;
      avg_q <= 3'h0;
      storeDel_q <= 8'h00;
      chan_q <= 4'h0;
      pud_q <= `SAS_PUD_RESET; // (RULE2)
      ivl_q <= 8'h00;
    end else begin
      if (wrCtrl) begin
        enable_q <= hwdata[`SAS_CTRL_EN];
        cont_q <= hwdata[`SAS_CTRL_CONT];
        se_q <= hwdata[`SAS_CTRL_SE];
        chop_q <= hwdata[`SAS_CTRL_CHOP];
        irqEn_q <= hwdata[`SAS_CTRL_IRQEN];
        dmaEn_q <= hwdata[`SAS_CTRL_DMAEN];
      end
      if (wrCfg) begin
        attn_q <= hwdata[`SAS_CFG_ATTN_LSB +: 2];
        avg_q <= hwdata[`SAS_CFG_AVG_LSB +: 3];
        storeDel_q <= hwdata[`SAS_CFG_SDEL_LSB +: 8];
        chan_q <= hwdata[`SAS_CFG_CHAN_LSB +: 4];
      end
      if (wrTim) begin
        pud_q <= hwdata[`SAS_TIM_PUD_LSB +: 8];
        ivl_q <= hwdata[`SAS_TIM_IVL_LSB +: 8];
      end
    end
  end

  // start bit: set by software only while it reads zero (idle or power-up), cleared by hardware
  always @(posedge sys_clk) begin
    if (srst) begin
      start_q <= 1'b0;
    end else if (hwClrStart) begin
      start_q <= 1'b0; // (RULE5)
    end else if (wrCtrl && hwdata[`SAS_CTRL_START] && !start_q) begin
      start_q <= 1'b1; // (RULE4) (RULE6)
    end
  end

  // done flag: hardware set wins over a write-one clear
  always @(posedge sys_clk) begin
    if (srst) begin
      done_q <= 1'b0;
    end else if (hwSetDone) begin
      done_q <= 1'b1; // (RULE5)
    end else if (wrCtrl && hwdata[`SAS_CTRL_DONE]) begin
      done_q <= 1'b0; // (RULE21)
    end
  end

  // ------------------------------------------------------------------
  // conversion sequencer
  // ------------------------------------------------------------------
  always @* begin
    hwClrStart = 1'b0;
    hwSetDone = 1'b0;
    if (state_q == S_STORE) begin
      hwSetDone = 1'b1; // (RULE5)
      hwClrStart = !cont_q; // (RULE8)
    end
    if (!enable_q) begin
      hwClrStart = 1'b1;
    end
  end

  always @(posedge sys_clk) begin // (RULE3)
    if (srst) begin
      state_q <= S_OFF;
      ldoEnable <= 1'b0;
      adcEnable <= 1'b0;
      convStart <= 1'b0;
      channelSel <= 4'h0;
      singleEnded <= 1'b0;
      attenuation <= 2'h0;
      offsetSign <= 1'b0;
      pwrCnt_q <= 10'h000;
      dlyCnt_q <= 9'h000;
      smpCnt_q <= 8'h00;
      gapCnt_q <= 8'h00;
      acc_q <= 17'h00000;
      result_q <= 16'h0000;
      dmaReq <= 1'b0;
    end else begin
      convStart <= 1'b0;
      dmaReq <= 1'b0;
      if (!enable_q) begin
        state_q <= S_OFF;
        ldoEnable <= 1'b0;
        adcEnable <= 1'b0;
      end else begin
        case (state_q)
          S_OFF: begin
            ldoEnable <= 1'b1; // (RULE1)
            pwrCnt_q <= {pud_q, 2'b00} - 10'h001; // (RULE2)
            state_q <= S_PWRUP;
          end
          S_PWRUP: begin
            if (pwrCnt_q == 10'h000 || pwrCnt_q == 10'h3FF) begin
              adcEnable <= 1'b1; // (RULE1)
              state_q <= S_IDLE;
            end else begin
              pwrCnt_q <= pwrCnt_q - 10'h001;
            end
          end
          S_IDLE: begin
            if (start_q) begin
              channelSel <= chan_q; // (RULE14)
              singleEnded <= se_q; // (RULE15)
              attenuation <= attn_q; // (RULE16)
              offsetSign <= 1'b0;
              acc_q <= 17'h00000;
              smpCnt_q <= 8'h00;
              dlyCnt_q <= {1'b0, storeDel_q};
              convStart <= 1'b1; // (RULE4)
              state_q <= S_CONV;
            end
          end
          S_CONV: begin
            if (storeNow) begin
              acc_q <= acc_q + {7'h00, convData}; // (RULE17)
              if (smpCnt_q + 8'h01 == smpTotal) begin
                state_q <= S_STORE;
              end else begin
                smpCnt_q <= smpCnt_q + 8'h01;
                if (chop_q) begin
                  offsetSign <= ~offsetSign; // (RULE20)
                end
                dlyCnt_q <= {1'b0, storeDel_q};
                convStart <= 1'b1;
              end
            end else if (storeDel_q != 8'h00) begin
              dlyCnt_q <= dlyCnt_q - 9'h001;
            end
          end
          S_STORE: begin
            result_q <= scaled[15:0]; // (RULE9)
            dmaReq <= dmaEn_q; // (RULE22)
            acc_q <= 17'h00000;
            smpCnt_q <= 8'h00;
            offsetSign <= 1'b0;
            if (!cont_q) begin
              state_q <= S_IDLE;
            end else if (ivl_q == 8'h00) begin
              dlyCnt_q <= {1'b0, storeDel_q};
              convStart <= 1'b1; // (RULE12) (RULE8)
              state_q <= S_CONV;
            end else begin
              gapCnt_q <= ivl_q; // (RULE12)
              state_q <= S_GAP;
            end
          end
          S_GAP: begin
            if (tick) begin // (RULE13)
              if (gapCnt_q == 8'h01) begin
                dlyCnt_q <= {1'b0, storeDel_q};
                convStart <= 1'b1;
                state_q <= S_CONV;
              end else begin
                gapCnt_q <= gapCnt_q - 8'h01;
              end
            end
          end
          default: begin
            state_q <= S_OFF;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // interrupt output
  // ------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= (done_q | hwSetDone) & irqEn_q; // (RULE21)
    end
  end
endmodule // sas_sequencer
`default_nettype wire

/* File: tb/sas_seq_assertions.sv */
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module sas_checker (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ldoEnable,
  input wire logic adcEnable,
  input wire logic convStart,
  input wire logic [3:0] channelSel,
  input wire logic singleEnded,
  input wire logic [1:0] attenuation,
  input wire logic offsetSign,
  input wire logic dmaReq
);
  // ----------------------------------------
  // power-up and conversion control
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_adcLdo; adcEnable |-> ldoEnable; endproperty
  a_adcLdo: assert property (p_adcLdo) else $error("converter on without regulator");
  property p_ldoWait; $rose(ldoEnable) |=> !adcEnable [*4]; endproperty
  a_ldoWait: assert property (p_ldoWait) else $error("converter on too soon");
  property p_convAdc; convStart |-> adcEnable; endproperty
  a_convAdc: assert property (p_convAdc) else $error("start while converter off");
  property p_startPulse; convStart |=> !convStart; endproperty
  a_startPulse: assert property (p_startPulse) else $error("start pulse too long");
  property p_cfgHold;
    convStart |=> $stable(channelSel) && $stable(singleEnded) && $stable(attenuation);
  endproperty
  a_cfgHold: assert property (p_cfgHold) else $error("input select moved");
  property p_dmaPulse; dmaReq |=> !dmaReq; endproperty
  a_dmaPulse: assert property (p_dmaPulse) else $error("dma request too long");
  property p_offStop; !ldoEnable |-> !convStart; endproperty
  a_offStop: assert property (p_offStop) else $error("start while disabled");
  property p_ldoOff; $fell(ldoEnable) |-> !adcEnable; endproperty
  a_ldoOff: assert property (p_ldoOff) else $error("converter left on");
  property p_signStart; $rose(offsetSign) |-> convStart; endproperty
  a_signStart: assert property (p_signStart) else $error("sign flipped outside a start");
  c_start: cover property (convStart);
  c_chop: cover property ($rose(offsetSign));
  c_dma: cover property (dmaReq);
  c_adc: cover property ($rose(adcEnable));
endmodule // sas_checker
bind sas_sequencer sas_checker u_chk (.sys_clk(sys_clk), .srst(srst), .ldoEnable(ldoEnable),
  .adcEnable(adcEnable), .convStart(convStart), .channelSel(channelSel),
  .singleEnded(singleEnded), .attenuation(attenuation), .offsetSign(offsetSign),
  .dmaReq(dmaReq));
`default_nettype wire

/* File: tb/sas_conv_model.sv */
// behavioural analog converter core: answers a start after 3 or 12 cycles
`timescale 1ns/1ps
`default_nettype none
module sas_conv_model (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic slow,
  input wire logic convStart,
  input wire logic [3:0] channelSel,
  input wire logic offsetSign,
  output logic convDone,
  output logic [9:0] convData
);
  logic [3:0] cnt;
  logic [9:0] smp;
  always @(posedge sys_clk) begin
    if (srst) begin
      convDone <= 1'b0;
      convData <= 10'h000;
      cnt <= 4'h0;
    end else begin
      if (convStart) begin
        cnt <= slow ? 4'hC : 4'h3;
        smp <= 10'h100 + {3'h0, channelSel, 3'h0} + {9'h0, offsetSign};
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
      if (!convStart && cnt == 4'h1) begin
        convDone <= 1'b1;
        convData <= smp;
      end else begin
        convDone <= 1'b0;
        // data lines toggle whenever no result is presented
        convData <= ~convData;
      end
    end
  end
endmodule // sas_conv_model
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the sar adc sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sas_consts.vh"
module tb;
  logic sys_clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, ldoEnable, adcEnable, convStart, singleEnded, offsetSign;
  logic convDone, irq, dmaReq;
  logic [3:0] channelSel;
  logic [1:0] attenuation;
  logic [9:0] convData;
  int errCount = 0, checksDone = 0, cyc = 0, nStart = 0, nDma = 0;
  always #12.5 sys_clk = ~sys_clk;
  sas_sequencer #(.TICK_CYCLES(16)) DUT (.sys_clk(sys_clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ldoEnable(ldoEnable), .adcEnable(adcEnable), .convStart(convStart),
    .channelSel(channelSel), .singleEnded(singleEnded), .attenuation(attenuation),
    .offsetSign(offsetSign), .convDone(convDone), .convData(convData), .irq(irq),
    .dmaReq(dmaReq));
  sas_conv_model u_conv (.sys_clk(sys_clk), .srst(srst), .slow(slow), .convStart(convStart),
    .channelSel(channelSel), .offsetSign(offsetSign), .convDone(convDone),
    .convData(convData));
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    nStart <= nStart + 32'(convStart);
    nDma <= nDma + 32'(dmaReq);
    if (cyc == 5000) begin
      errCount = errCount + 1;
      finalReport();
    end
  end
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge sys_clk); while (!hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (!hreadyout);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic tPower();
    int n;
    rdc(`SAS_OFS_TIMING, 32'h40);
    rdc(8'h14, 32'h0);
    wr(`SAS_OFS_TIMING, 32'h2);
    wr(`SAS_OFS_CTRL, 32'h1);
    n = 0;
    while (!adcEnable) begin
      @(posedge sys_clk);
      n++;
    end
    chk(32'(n >= 8 && n <= 12), 32'h1);
    bus(1'b0, `SAS_OFS_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h3);
  endtask
  task automatic tSingle();
    slow <= 1'b1;
    wr(`SAS_OFS_CFG, 32'h0005_0002);
    wr(`SAS_OFS_CTRL, 32'hC3);
    rdc(`SAS_OFS_CTRL, 32'hC3);
    wr(`SAS_OFS_CTRL, 32'hC3);
    do @(posedge sys_clk); while (!dmaReq);
    chk({25'h0, channelSel, singleEnded, attenuation}, 32'h2A);
    repeat (2) @(posedge sys_clk);
    chk(32'(nStart), 32'h1);
    chk({31'h0, irq}, 32'h1);
    rdc(`SAS_OFS_CTRL, 32'hE1);
    rdc(`SAS_OFS_RESULT, {16'h0, 10'h128, 6'h0});
    chk(32'(nDma), 32'h1);
    wr(`SAS_OFS_CTRL, 32'hE1);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic tDelay();
    int n;
    wr(`SAS_OFS_CFG, 32'h0000_0400);
    wr(`SAS_OFS_CTRL, 32'h83);
    do @(posedge sys_clk); while (!convStart);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!dmaReq);
    chk(32'(n == 5 || n == 6), 32'h1);
  endtask
  task automatic tCont();
    int n;
    slow <= 1'b0;
    wr(`SAS_OFS_CFG, 32'h0003_0004);
    n = nStart;
    wr(`SAS_OFS_CTRL, 32'hBF);
    repeat (3) do @(posedge sys_clk); while (!dmaReq);
    chk({31'h0, singleEnded}, 32'h1);
    rdc(`SAS_OFS_RESULT, 32'h4620);
    chk(32'(nStart - n >= 6), 32'h1);
    wr(`SAS_OFS_CTRL, 32'h99);
    do bus(1'b0, `SAS_OFS_CTRL, 32'h0); while (rd[1]);
    n = nStart;
    repeat (30) @(posedge sys_clk);
    chk(32'(nStart - n), 32'h0);
    wr(`SAS_OFS_TIMING, 32'h0202);
    wr(`SAS_OFS_CFG, 32'h0);
    wr(`SAS_OFS_CTRL, 32'h87);
    do @(posedge sys_clk); while (!dmaReq);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!convStart);
    chk(32'(n > 16 && n <= 34), 32'h1);
    wr(`SAS_OFS_CTRL, 32'h81);
    do bus(1'b0, `SAS_OFS_CTRL, 32'h0); while (rd[1]);
    wr(`SAS_OFS_CTRL, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk({30'h0, ldoEnable, adcEnable}, 32'h0);
  endtask
  task automatic finalReport();
    $display("errors=%0d checks=%0d", errCount, checksDone);
    if (errCount == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    tPower();
    tSingle();
    tDelay();
    tCont();
    finalReport();
  end
endmodule // tb
`default_nettype wire
